// ==== src/divided_clock_output_map.svh ====
// Purpose: register offsets, field positions, reset values and timing counts
// Assumes: 32-bit APB data, one register per aligned word
// Notes: included by the clock output divider and by the bench
`ifndef DIVIDED_CLOCK_OUTPUT_MAP_SVH
`define DIVIDED_CLOCK_OUTPUT_MAP_SVH

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define CLOCK_OUT_SELECT_OFS 16'hFF40
`define PORT6_DIRECTION_OFS 16'hFF44
`define PORT6_LATCH_OFS 16'hFF48
`define CLOCK_OUT_STATUS_OFS 16'hFF4C
`define CLOCK_OUT_SET_OFS 16'hFF50
`define CLOCK_OUT_CLEAR_OFS 16'hFF54

// ----------------------------------------------------------------
// fields
// ----------------------------------------------------------------
`define ENABLE_BIT 4
`define RATE_MSB 2
`define RATE_LSB 0
`define SELECT_WRITABLE 8'h17
`define STATUS_RUN_BIT 0
`define STATUS_PIN_BIT 1
`define STATUS_DRAIN_BIT 2
`define STATUS_PORT_LSB 8

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CLOCK_OUT_SELECT_RST 8'h00
`define PORT6_DIRECTION_RST 8'hFF
`define PORT6_LATCH_RST 8'h00

// ----------------------------------------------------------------
// timing: system clock cycles per main clock (fx) period
// ----------------------------------------------------------------
`define FX_DIV 2

`endif

// ==== src/divided_clock_output_pkg.sv ====
// Purpose: types shared by the clock output divider and its bench
// Assumes: APB4 style request signals
// Notes: constants live in divided_clock_output_map.svh
package divided_clock_output_pkg;

	// ----------------------------------------------------------------
	// divider sequencing
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		DIV_IDLE,
		DIV_RUN,
		DIV_DRAIN
	} div_state_e;

	// ----------------------------------------------------------------
	// apb request from the master
	// ----------------------------------------------------------------
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [15:0] paddr;
		logic [31:0] pwdata;
		logic [3:0] pstrb;
	} apb_req_s;

endpackage

// ==== src/divided_clock_output.sv ====
// Purpose: divided clock output on the shared port 6 bit 0 pin, APB slave
// Assumes: sys_clk_i is the only clock; fx = sys_clk_i / FX_DIV
// Notes: zero wait state APB, unmapped addresses answer pslverr
//
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
`include "divided_clock_output_map.svh"

module divided_clock_output #(
	parameter int FX_DIV = `FX_DIV,
	parameter int PORT_W = 8
) (
	input wire logic sys_clk_i, // system clock
	input wire logic rst_i, // synchronous reset, active high
	input wire divided_clock_output_pkg::apb_req_s apb_i, // apb request
	output logic pready_o, // apb ready
	output logic [31:0] prdata_o, // apb read data
	output logic pslverr_o, // apb error
	input wire logic sound_amplitude_i, // sound amplitude output to share the pin
	input wire logic [PORT_W-1:0] port6_i, // port 6 pin levels
	output logic [PORT_W-1:0] port6_o, // port 6 pin drive values
	output logic [PORT_W-1:0] port6_oe_o, // port 6 output enables
	output logic divided_clock_o // divided clock before pin muxing
);
	import divided_clock_output_pkg::*;

	// ----------------------------------------------------------------
	// elaboration checks
	// ----------------------------------------------------------------
	localparam int HALF_FX = FX_DIV / 2;
	localparam int MAX_HALF = HALF_FX * 128;
	localparam int CW = $clog2(MAX_HALF + 1);

	initial begin
		if (FX_DIV < 2 || (FX_DIV % 2) != 0) begin
			$error("FX_DIV must be even and at least 2");
		end
		if (PORT_W < 1 || PORT_W > 8) begin
			$error("PORT_W must be 1 to 8");
		end
	end

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic addr_hit(input logic [15:0] addr, input logic [15:0] ofs);
		addr_hit = (addr[15:2] == ofs[15:2]);
	endfunction

	// half period in system cycles for a rate code
	function automatic logic [CW-1:0] half_len(input logic [2:0] rate);
		logic [CW:0] v;
		v = (CW+1)'(HALF_FX) << rate;
		half_len = v[CW-1:0];
	endfunction

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [7:0] select_q;
	logic [7:0] select_d;
	logic [PORT_W-1:0] dir_q;
	logic [PORT_W-1:0] dir_d;
	logic [PORT_W-1:0] latch_q;
	logic [PORT_W-1:0] latch_d;
	logic [PORT_W-1:0] port_meta_q;
	logic [PORT_W-1:0] port_sync_q;
	div_state_e state_q;
	div_state_e state_d;
	logic [CW-1:0] cnt_q;
	logic [CW-1:0] cnt_d;
	logic clk_q;
	logic clk_d;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic err_q;
	logic pin0_q;
	logic pin0_d;

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	wire setup = apb_i.psel & ~apb_i.penable;
	wire access = apb_i.psel & apb_i.penable;
	wire wr = access & apb_i.pwrite & apb_i.pstrb[0];
	wire hit_sel = addr_hit(apb_i.paddr, `CLOCK_OUT_SELECT_OFS);
	wire hit_dir = addr_hit(apb_i.paddr, `PORT6_DIRECTION_OFS);
	wire hit_lat = addr_hit(apb_i.paddr, `PORT6_LATCH_OFS);
	wire hit_sts = addr_hit(apb_i.paddr, `CLOCK_OUT_STATUS_OFS);
	wire hit_set = addr_hit(apb_i.paddr, `CLOCK_OUT_SET_OFS);
	wire hit_clr = addr_hit(apb_i.paddr, `CLOCK_OUT_CLEAR_OFS);
	wire mapped = hit_sel | hit_dir | hit_lat | hit_sts | hit_set | hit_clr;
	wire [7:0] wbyte = apb_i.pwdata[7:0];

	// ----------------------------------------------------------------
	// register writes
	// ----------------------------------------------------------------
	// byte write, or set/clear masks for one-bit updates
	// reserved bits never store, so they always read zero
	wire [7:0] sel_byte = wr & hit_sel ? wbyte : select_q;
	wire [7:0] sel_set = wr & hit_set ? (sel_byte | wbyte) : sel_byte;
	wire [7:0] sel_clr = wr & hit_clr ? (sel_set & ~wbyte) : sel_set;
	assign select_d = sel_clr & `SELECT_WRITABLE;
	assign dir_d = wr & hit_dir ? wbyte[PORT_W-1:0] : dir_q;
	assign latch_d = wr & hit_lat ? wbyte[PORT_W-1:0] : latch_q;

	wire enable = select_q[`ENABLE_BIT];
	wire [2:0] rate = select_q[`RATE_MSB:`RATE_LSB];

	// ----------------------------------------------------------------
	// read data, captured in the setup cycle
	// ----------------------------------------------------------------
	logic [31:0] status_word;
	always_comb begin
		status_word = 32'h0000_0000;
		status_word[`STATUS_RUN_BIT] = (state_q != DIV_IDLE);
		status_word[`STATUS_PIN_BIT] = pin0_q;
		status_word[`STATUS_DRAIN_BIT] = (state_q == DIV_DRAIN);
		status_word[`STATUS_PORT_LSB +: PORT_W] = port_sync_q;
	end

	wire [31:0] rd_sel = {24'h00_0000, select_q};
	wire [31:0] rd_dir = {{(32-PORT_W){1'b0}}, dir_q};
	wire [31:0] rd_lat = {{(32-PORT_W){1'b0}}, latch_q};
	assign rdata_d = hit_sel | hit_set | hit_clr ? rd_sel :
		hit_dir ? rd_dir :
		hit_lat ? rd_lat :
		hit_sts ? status_word :
		32'h0000_0000;

	// ----------------------------------------------------------------
	// divider sequencing
	// ----------------------------------------------------------------
	// the counter only runs outside idle, so starting always begins
	// with a full low phase and stopping waits for the high to end
	wire [CW-1:0] half = half_len(rate);
	wire phase_end = (cnt_q == half - CW'(1));

	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		clk_d = clk_q;
		unique case (state_q)
			DIV_IDLE: begin
				cnt_d = '0;
				clk_d = 1'b0;
				if (enable) begin
					state_d = DIV_RUN;
				end
			end
			DIV_RUN: begin
				cnt_d = phase_end ? '0 : cnt_q + CW'(1);
				clk_d = phase_end ? ~clk_q : clk_q;
				if (!enable && !clk_q) begin
					state_d = DIV_IDLE;
					cnt_d = '0;
					clk_d = 1'b0;
				end else if (!enable) begin
					state_d = DIV_DRAIN;
				end
			end
			DIV_DRAIN: begin
				cnt_d = phase_end ? '0 : cnt_q + CW'(1);
				if (phase_end) begin
					state_d = DIV_IDLE;
					clk_d = 1'b0;
				end
			end
		endcase
	end

	// ----------------------------------------------------------------
	// pin mux for port 6
	// ----------------------------------------------------------------
	// bit 0 carries latch, divided clock and sound amplitude together;
	// a set latch or active sound overrides the clock, hence the
	// enable order that software follows
	assign pin0_d = latch_d[0] | clk_d | sound_amplitude_i;

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			select_q <= `CLOCK_OUT_SELECT_RST;
			dir_q <= PORT_W'(`PORT6_DIRECTION_RST);
			latch_q <= PORT_W'(`PORT6_LATCH_RST);
		end else begin
			select_q <= select_d;
			dir_q <= dir_d;
			latch_q <= latch_d;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			state_q <= DIV_IDLE;
			cnt_q <= '0;
			clk_q <= 1'b0;
			pin0_q <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			clk_q <= clk_d;
			pin0_q <= pin0_d;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			rdata_q <= 32'h0000_0000;
			err_q <= 1'b0;
		end else if (setup) begin
			rdata_q <= rdata_d;
			err_q <= ~mapped;
		end
	end

	// two-stage synchroniser for the pin levels
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			port_meta_q <= '0;
			port_sync_q <= '0;
		end else begin
			port_meta_q <= port6_i;
			port_sync_q <= port_meta_q;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign pready_o = 1'b1;
	assign prdata_o = rdata_q;
	assign pslverr_o = err_q & access;
	assign divided_clock_o = clk_q;
	assign port6_oe_o = ~dir_q;

	// bit 0 comes from the muxed flop, the rest straight from the latch
	generate
		for (genvar i = 0; i < PORT_W; i++) begin : g_port
			if (i == 0) begin : g_pin0
				assign port6_o[i] = pin0_q;
			end else begin : g_pinn
				assign port6_o[i] = latch_q[i];
			end
		end
	endgenerate

endmodule

// ==== verif/clock_receiver_model.sv ====
// Purpose: far-side receiver that times the clock seen on the shared pin
// Assumes: pin level already resolved by the bench, pull-down when undriven
// Notes: widths are in system clock cycles
`timescale 1ns/1ps
module clock_receiver_model (
	input wire logic sys_clk_i, // sampling clock
	input wire logic rst_i, // synchronous reset
	input wire logic pin_i, // resolved pin level
	output logic [7:0] rises_o, // rising edges seen
	output logic [8:0] hi_o, // last high width
	output logic [8:0] lo_o // last low width
);
	logic prev_q;
	logic [8:0] cnt_q;
	always_ff @(posedge sys_clk_i) begin
		prev_q <= pin_i;
		cnt_q <= (pin_i != prev_q) ? 9'h001 : cnt_q + 9'h001;
		if (rst_i) begin
			rises_o <= 8'h00;
		end else if (pin_i && !prev_q) begin
			lo_o <= cnt_q;
			rises_o <= rises_o + 8'h01;
		end else if (!pin_i && prev_q) begin
			hi_o <= cnt_q;
		end
	end
endmodule

// ==== verif/divided_clock_output_monitor.sv ====
// Purpose: port-level checks of the clock output divider
// Assumes: shadows of select, direction and latch follow apb writes
// Notes: rate changes only while stopped, so half width follows the shadow
`timescale 1ns/1ps
`include "divided_clock_output_map.svh"
module divided_clock_output_monitor
import divided_clock_output_pkg::*;
#(parameter int FX_DIV = `FX_DIV, parameter int PORT_W = 8) (
	input wire logic sys_clk_i, // clock
	input wire logic rst_i, // reset
	input wire divided_clock_output_pkg::apb_req_s apb_i, // apb request
	input wire logic pready_o, // ready
	input wire logic [31:0] prdata_o, // read data
	input wire logic pslverr_o, // error
	input wire logic sound_amplitude_i, // sound level
	input wire logic [PORT_W-1:0] port6_i, // pins
	input wire logic [PORT_W-1:0] port6_o, // drive
	input wire logic [PORT_W-1:0] port6_oe_o, // enables
	input wire logic divided_clock_o // divided clock
);
	logic [7:0] sel_q, dir_q, lat_q;
	logic [8:0] cnt_q;
	logic last_q, seen_q;
	wire logic [15:0] a = apb_i.paddr;
	wire logic acc = apb_i.psel & apb_i.penable;
	wire logic wr = acc & pready_o & apb_i.pwrite & apb_i.pstrb[0];
	wire logic [7:0] wd = apb_i.pwdata[7:0];
	// the slave decodes whole words, so any byte lane of a register maps
	wire logic mapped = a >= `CLOCK_OUT_SELECT_OFS && a <= (`CLOCK_OUT_CLEAR_OFS | 16'h0003);
	wire logic [8:0] half = 9'((FX_DIV / 2) << sel_q[2:0]);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	always_ff @(posedge sys_clk_i) begin
		last_q <= rst_i ? 1'b0 : divided_clock_o;
		cnt_q <= (divided_clock_o != last_q) ? 9'h001 : cnt_q + 9'h001;
		seen_q <= !rst_i && sel_q[4] && (seen_q || (last_q && !divided_clock_o));
		if (rst_i) begin
			sel_q <= 8'h00;
			dir_q <= 8'hFF;
			lat_q <= 8'h00;
		end else if (wr) begin
			if (a == `CLOCK_OUT_SELECT_OFS) sel_q <= wd & `SELECT_WRITABLE;
			if (a == `CLOCK_OUT_SET_OFS) sel_q <= sel_q | (wd & `SELECT_WRITABLE);
			if (a == `CLOCK_OUT_CLEAR_OFS) sel_q <= sel_q & ~wd;
			if (a == `PORT6_DIRECTION_OFS) dir_q <= wd;
			if (a == `PORT6_LATCH_OFS) lat_q <= wd;
		end
	end
	property p_ready; pready_o; endproperty
	a_ready: assert property (p_ready) else $error("ready dropped");
	property p_err; acc |-> pslverr_o == !mapped; endproperty
	a_err: assert property (p_err) else $error("wrong error response");
	property p_rd_sel; acc && !apb_i.pwrite && a == `CLOCK_OUT_SELECT_OFS |-> prdata_o == {24'h0, sel_q}; endproperty
	a_rd_sel: assert property (p_rd_sel) else $error("select readback wrong");
	property p_oe; port6_oe_o == ~dir_q[PORT_W-1:0]; endproperty
	a_oe: assert property (p_oe) else $error("output enable mismatch");
	property p_start_low; $rose(sel_q[4]) |-> !divided_clock_o ##1 !divided_clock_o; endproperty
	a_start_low: assert property (p_start_low) else $error("output not starting low");
	property p_high_len; last_q && !divided_clock_o |-> cnt_q == half; endproperty
	a_high_len: assert property (p_high_len) else $error("high phase width wrong");
	property p_low_len; seen_q && !last_q && divided_clock_o |-> cnt_q == half; endproperty
	a_low_len: assert property (p_low_len) else $error("low phase width wrong");
	property p_idle_low; !sel_q[4] && !divided_clock_o |=> !divided_clock_o; endproperty
	a_idle_low: assert property (p_idle_low) else $error("clock moved while stopped");
	property p_pin; !lat_q[0] && !$past(lat_q[0]) && !sound_amplitude_i && !$past(sound_amplitude_i)
		|-> port6_o[0] == divided_clock_o; endproperty
	a_pin: assert property (p_pin) else $error("pin does not carry clock");
endmodule
bind divided_clock_output divided_clock_output_monitor #(.FX_DIV(FX_DIV), .PORT_W(PORT_W)) u_mon (
	.sys_clk_i(sys_clk_i), .rst_i(rst_i), .apb_i(apb_i), .pready_o(pready_o), .prdata_o(prdata_o),
	.pslverr_o(pslverr_o), .sound_amplitude_i(sound_amplitude_i), .port6_i(port6_i), .port6_o(port6_o),
	.port6_oe_o(port6_oe_o), .divided_clock_o(divided_clock_o));

// ==== verif/divided_clock_output_tb.sv ====
// Purpose: apb driven tests of the clock output divider
// Assumes: FX_DIV of 2, so half width is 1 << rate cycles
// Notes: undriven pins read a fixed external pattern
`timescale 1ns/1ps
`include "divided_clock_output_map.svh"
module divided_clock_output_tb;
	import divided_clock_output_pkg::*;
	logic clk, rst, sound, pready, perr, dclk, pin, er;
	apb_req_s req;
	logic [31:0] prdata, rd;
	logic [7:0] p6i, p6o, p6oe, rises, r0;
	logic [8:0] hi_w, lo_w;
	int n_fail, total_checks, h;
	assign pin = p6oe[0] ? p6o[0] : 1'b0;
	assign p6i = (p6oe & p6o) | (~p6oe & 8'hA5);
	divided_clock_output #(.FX_DIV(2), .PORT_W(8)) DUT (.sys_clk_i(clk), .rst_i(rst), .apb_i(req),
		.pready_o(pready), .prdata_o(prdata), .pslverr_o(perr), .sound_amplitude_i(sound), .port6_i(p6i),
		.port6_o(p6o), .port6_oe_o(p6oe), .divided_clock_o(dclk));
	clock_receiver_model u_rx (.sys_clk_i(clk), .rst_i(rst), .pin_i(pin), .rises_o(rises), .hi_o(hi_w), .lo_o(lo_w));
	// only the watchdog ends a wait; one idle edge after each transfer
	// keeps a following call from driving psel twice in one time step
	task automatic apb(input logic w, input logic [15:0] a, input logic [7:0] d);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: {24'h0, d}, pstrb: 4'hF};
		@(posedge clk);
		req.penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = perr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		repeat (30000) @(posedge clk);
		n_fail++;
		$display("Error at %0t: watchdog timeout", $time);
		print_verdict();
	end
	initial begin
		rst = 1'b1;
		req = '0;
		sound = 1'b0;
		n_fail = 0;
		total_checks = 0;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		apb(0, `CLOCK_OUT_SELECT_OFS, 8'h00); chk(rd, 32'h00);
		apb(0, `PORT6_DIRECTION_OFS, 8'h00); chk(rd, 32'hFF);
		apb(0, `CLOCK_OUT_STATUS_OFS, 8'h00); chk(rd, 32'h0000_A500);
		apb(0, 16'hFF60, 8'h00); chk(er, 1'b1);
		apb(1, `CLOCK_OUT_SELECT_OFS, 8'hEF);
		apb(0, `CLOCK_OUT_SELECT_OFS, 8'h00); chk(rd, 32'h07);
		apb(1, `CLOCK_OUT_SET_OFS, 8'h10);
		apb(0, `CLOCK_OUT_SELECT_OFS, 8'h00); chk(rd, 32'h17);
		apb(1, `CLOCK_OUT_CLEAR_OFS, 8'h10);
		apb(0, `CLOCK_OUT_SELECT_OFS, 8'h00); chk(rd, 32'h07);
		repeat (300) @(posedge clk);
		$display("test registers done");
		for (int r = 0; r < 8; r++) begin
			h = 1 << r;
			apb(1, `CLOCK_OUT_SELECT_OFS, 8'(r));
			apb(1, `PORT6_LATCH_OFS, 8'h00);
			apb(1, `PORT6_DIRECTION_OFS, 8'hFE); chk(p6oe, 32'h01);
			r0 = rises;
			apb(1, `CLOCK_OUT_SELECT_OFS, 8'(r) | 8'h10);
			while (8'(rises - r0) < 8'd3) begin
				@(posedge clk);
			end
			chk(hi_w, h);
			chk(lo_w, h);
			while (pin !== r[0]) begin
				@(posedge clk);
			end
			apb(1, `CLOCK_OUT_SELECT_OFS, 8'(r));
			repeat (2 * h + 4) @(posedge clk);
			chk(dclk, 1'b0);
			chk(hi_w, h);
			$display("test rate %0d done", r);
		end
		apb(1, `PORT6_LATCH_OFS, 8'hA1);
		repeat (2) @(posedge clk);
		chk(p6o[0], 1'b1);
		chk(p6o[7:1], 7'h50);
		apb(1, `PORT6_LATCH_OFS, 8'h00);
		sound <= 1'b1;
		repeat (3) @(posedge clk);
		chk(p6o[0], 1'b1);
		sound <= 1'b0;
		$display("test pin sharing done");
		print_verdict();
	end
endmodule
